// file: src/ecu_capture_top.sv
// extended capture unit: captures, holding registers, accumulators, modulus counter
`timescale 1ns/1ps

// How it works
// R1 - eight channels, each capture or compare by its function select bit; the code has no compare logic, a set bit only blocks capture
// R2 - a 16-bit main counter behind a prescaler is the captured time base
// R3 - the main counter prescaler is seven bits wide
// R4 - software reads counter and capture registers as whole words
// R5 - four channels have one capture register, four add a holding register
// R6 - capture empties on read or latch; holding empties on read
// R7 - non-buffered capture stores the count, replacing old value when unprotected
// R8 - protected non-buffered capture writes only into an empty register
// R9 - latch mode copies capture to holding on zero, zero write, force latch
// R10 - unprotected latch mode overwrites capture and holding on each event
// R11 - protected buffered channels write a register only when it is empty
// R12 - unprotected queue mode shifts capture to holding, loads the new count
// R13 - queue mode holding read copies the accumulator to its holding register
// R14 - four 8-bit accumulators with holding registers count channel edges
// R15 - saturate bit stops 8-bit accumulators at all ones
// R16 - each accumulator pair can run as one 16-bit accumulator
// R17 - 16-bit modulus down-counter with a 4-bit prescaler
// R18 - modulus count reaching zero can latch captures and accumulators
// R19 - four selectable delay counters filter the buffered inputs
// R20 - accumulator latch mode copies and clears on the latch events
// R21 - accumulator queue mode copies and clears on holding read
// R22 - function select zero means capture, one means compare; here one only blocks capture, no compare is built
// R23 - full flags track every capture and holding register
module ecu_capture_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] ch_pin_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [1:0] es, input logic lvl);
        return (es[0] & lvl) | (es[1] & ~lvl);
    endfunction : hit

    function automatic logic [6:0] mask7(input logic [2:0] s);
        logic [6:0] m;
        m = '0;
        for (int k = 0; k < 7; k++) begin
            if (k < int'(s)) begin
                m[k] = 1'b1;
            end
        end
        return m;
    endfunction : mask7

    // divide by 1, 4, 8 or 16
    function automatic logic [3:0] mask4(input logic [1:0] s);
        logic [3:0] m;
        m = '0;
        for (int k = 0; k < 4; k++) begin
            if (s != 2'h0 && k <= int'(s)) begin
                m[k] = 1'b1;
            end
        end
        return m;
    endfunction : mask4

    function automatic logic [15:0] wm16(input logic [15:0] old, input logic [15:0] d,
                                         input logic [1:0] be);
        return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : wm16

    ecu_pkg::ecu_st_t q, n;
    logic acc, rd, wr, ttick, mtick, zero, force_lat, wr_zero, latch;
    logic [7:0] edg, cap_ev, crd, a;
    logic [3:0] hrd, xfer;
    logic [15:0] wv, p16;

    always_comb begin
        n = q;
        a = wb_adr_i;
        acc = wb_cyc_i & wb_stb_i & ~q.ack;
        rd = acc & ~wb_we_i;
        wr = acc & wb_we_i;
        n.ack = acc;
        n.rdat = 32'h0000_0000;
        edg = '0;
        cap_ev = '0;
        crd = '0;
        hrd = '0;
        xfer = '0;
        zero = 1'b0;
        force_lat = 1'b0;
        wr_zero = 1'b0;
        wv = ecu_pkg::ZERO16;
        p16 = ecu_pkg::ZERO16;

        // ------------------------------------------------------------
        // input synchronisers and filters
        // ------------------------------------------------------------
        n.s1 = ch_pin_i;
        n.s2 = q.s1;
        // R19 delay counters
        for (int i = 0; i < ecu_pkg::NBUF; i++) begin
            if (q.s2[i] != q.flt[i]) begin
                if (q.dly[i] >= q.dly_val) begin
                    n.flt[i] = q.s2[i];
                    n.dly[i] = 8'h00;
                    edg[i] = hit(q.edge_sel[2*i +: 2], q.s2[i]);
                end else begin
                    n.dly[i] = q.dly[i] + 8'h01;
                end
            end else begin
                n.dly[i] = 8'h00;
            end
        end
        for (int i = ecu_pkg::NBUF; i < ecu_pkg::NCH; i++) begin
            if (q.s2[i] != q.flt[i]) begin
                n.flt[i] = q.s2[i];
                edg[i] = hit(q.edge_sel[2*i +: 2], q.s2[i]);
            end
        end

        // ------------------------------------------------------------
        // main time base
        // ------------------------------------------------------------
        // R3 seven-bit prescaler
        ttick = q.ctrl[ecu_pkg::CT_EN]
              & ((q.pre & mask7(q.ctrl[ecu_pkg::CT_PS +: 3])) == mask7(q.ctrl[ecu_pkg::CT_PS +: 3]));
        if (q.ctrl[ecu_pkg::CT_EN]) begin
            n.pre = q.pre + 7'h01;
        end
        // R2 main counter step
        if (ttick) begin
            n.cnt = q.cnt + 16'h0001;
        end

        // ------------------------------------------------------------
        // modulus down-counter
        // ------------------------------------------------------------
        // R17 prescaled down count
        mtick = q.mctl[ecu_pkg::MC_EN]
              & ((q.mpre & mask4(q.mctl[ecu_pkg::MC_PS +: 2])) == mask4(q.mctl[ecu_pkg::MC_PS +: 2]));
        if (q.mctl[ecu_pkg::MC_EN]) begin
            n.mpre = q.mpre + 4'h1;
        end
        if (mtick) begin
            if (q.mcnt == ecu_pkg::ZERO16) begin
                if (q.mctl[ecu_pkg::MC_PER]) begin
                    n.mcnt = q.mrld;
                end
            end else begin
                n.mcnt = q.mcnt - 16'h0001;
                zero = (q.mcnt == ecu_pkg::MOD_ONE);
            end
        end

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr) begin
            case (a)
                ecu_pkg::ADR_CTRL: n.ctrl = wb_sel_i[0] ? wb_dat_i[7:0] : q.ctrl;
                ecu_pkg::ADR_FSEL: n.fsel = wb_sel_i[0] ? wb_dat_i[7:0] : q.fsel;
                ecu_pkg::ADR_NOVW: n.novw = wb_sel_i[0] ? wb_dat_i[7:0] : q.novw;
                ecu_pkg::ADR_DLY: n.dly_val = wb_sel_i[0] ? wb_dat_i[7:0] : q.dly_val;
                ecu_pkg::ADR_EDGE: begin
                    n.edge_sel = wm16(q.edge_sel, wb_dat_i[15:0], wb_sel_i[1:0]);
                end
                ecu_pkg::ADR_MCTL: begin
                    if (wb_sel_i[0]) begin
                        n.mctl = wb_dat_i[4:0];
                        force_lat = wb_dat_i[ecu_pkg::MC_FORCE];
                    end
                end
                ecu_pkg::ADR_MCNT: begin
                    wv = wm16(q.mrld, wb_dat_i[15:0], wb_sel_i[1:0]);
                    n.mrld = wv;
                    n.mcnt = wv;
                    n.mpre = 4'h0;
                    wr_zero = (wv == ecu_pkg::ZERO16);
                end
                ecu_pkg::ADR_MSTAT: begin
                    if (wb_sel_i[0] & wb_dat_i[ecu_pkg::MS_ZF]) begin
                        n.mzf = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // zero event beats a clear in the same cycle
        if (zero) begin
            n.mzf = 1'b1;
        end
        // R18 zero, zero write or force latch
        latch = force_lat | wr_zero | (zero & q.mctl[ecu_pkg::MC_ZLAT]);

        // ------------------------------------------------------------
        // register reads
        // ------------------------------------------------------------
        if (rd) begin
            if (a[7:5] == ecu_pkg::RGN_CAP) begin
                crd[a[4:2]] = 1'b1;
                n.rdat = {16'h0000, q.cap[a[4:2]]};
            end else if (a[7:4] == ecu_pkg::RGN_HOLD) begin
                hrd[a[3:2]] = 1'b1;
                n.rdat = {16'h0000, q.hold[a[3:2]]};
            end else if (a[7:4] == ecu_pkg::RGN_PA) begin
                n.rdat = {24'h00_0000, q.pa[a[3:2]]};
            end else if (a[7:4] == ecu_pkg::RGN_PAH) begin
                n.rdat = {24'h00_0000, q.pah[a[3:2]]};
            end else begin
                case (a)
                    ecu_pkg::ADR_CTRL: n.rdat = {24'h00_0000, q.ctrl};
                    ecu_pkg::ADR_FSEL: n.rdat = {24'h00_0000, q.fsel};
                    ecu_pkg::ADR_NOVW: n.rdat = {24'h00_0000, q.novw};
                    ecu_pkg::ADR_EDGE: n.rdat = {16'h0000, q.edge_sel};
                    ecu_pkg::ADR_DLY: n.rdat = {24'h00_0000, q.dly_val};
                    ecu_pkg::ADR_MCTL: n.rdat = {27'h000_0000, q.mctl};
                    ecu_pkg::ADR_MCNT: n.rdat = {16'h0000, q.mcnt};
                    ecu_pkg::ADR_MSTAT: n.rdat = {31'h0000_0000, q.mzf};
                    ecu_pkg::ADR_TCNT: n.rdat = {16'h0000, q.cnt};
                    ecu_pkg::ADR_FULL: n.rdat = {20'h0_0000, q.holdf, q.capf};
                    default: n.rdat = 32'h0000_0000;
                endcase
            end
        end
        // R6 reads empty the registers
        n.capf = q.capf & ~crd;
        n.holdf = q.holdf & ~hrd;

        // ------------------------------------------------------------
        // captures
        // ------------------------------------------------------------
        // R1 per-channel function select
        // R22 capture only on select zero
        for (int i = 0; i < ecu_pkg::NCH; i++) begin
            cap_ev[i] = edg[i] & ~q.fsel[i];
        end
        // R7 non-buffered capture
        for (int i = ecu_pkg::NBUF; i < ecu_pkg::NCH; i++) begin
            // R8 protected write only when empty
            if (cap_ev[i] & (~q.novw[i] | ~n.capf[i])) begin
                n.cap[i] = q.cnt;
                n.capf[i] = 1'b1;
            end
        end
        // R5 buffered channels keep a holding register
        for (int i = 0; i < ecu_pkg::NBUF; i++) begin
            // R9 latch into holding
            if (latch & q.ctrl[ecu_pkg::CT_LQ] & (~q.novw[i] | ~n.holdf[i])) begin
                n.hold[i] = q.cap[i];
                // R23 holding full, capture emptied
                n.holdf[i] = 1'b1;
                n.capf[i] = 1'b0;
            end
            if (cap_ev[i]) begin
                if (q.ctrl[ecu_pkg::CT_LQ]) begin
                    // R10 latch mode capture overwrite
                    if (~q.novw[i] | ~n.capf[i]) begin
                        n.cap[i] = q.cnt;
                        n.capf[i] = 1'b1;
                    end
                // R11 protected queue drops when both full
                end else if (~q.novw[i] | ~n.holdf[i] | ~n.capf[i]) begin
                    // R12 queue shift
                    if (n.capf[i]) begin
                        n.hold[i] = n.cap[i];
                        n.holdf[i] = 1'b1;
                    end
                    n.cap[i] = q.cnt;
                    n.capf[i] = 1'b1;
                end
            end
        end

        // ------------------------------------------------------------
        // pulse accumulators
        // ------------------------------------------------------------
        // R20 latch mode transfer; R21 queue mode transfer
        for (int i = 0; i < ecu_pkg::NBUF; i++) begin
            xfer[i] = q.ctrl[ecu_pkg::CT_LQ] ? latch : hrd[i];
        end
        for (int k = 0; k < 2; k++) begin
            // R16 paired 16-bit accumulator
            if (q.ctrl[ecu_pkg::CT_PAIR + k]) begin
                if (xfer[2*k] | xfer[2*k+1]) begin
                    n.pah[2*k] = q.pa[2*k];
                    n.pah[2*k+1] = q.pa[2*k+1];
                    n.pa[2*k] = 8'h00;
                    n.pa[2*k+1] = 8'h00;
                end
                if (edg[2*k]) begin
                    p16 = {n.pa[2*k+1], n.pa[2*k]} + 16'h0001;
                    n.pa[2*k+1] = p16[15:8];
                    n.pa[2*k] = p16[7:0];
                end
            end else begin
                for (int j = 2*k; j < 2*k + 2; j++) begin
                    // R13 copy and clear
                    if (xfer[j]) begin
                        n.pah[j] = q.pa[j];
                        n.pa[j] = 8'h00;
                    end
                    // R14 edge count; R15 saturation
                    if (edg[j] & ~(q.ctrl[ecu_pkg::CT_SAT] & (n.pa[j] == ecu_pkg::SAT_VAL))) begin
                        n.pa[j] = n.pa[j] + 8'h01;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // R2 counter advances
    cnt_step_a: assert property ( // R2
        ttick |=> q.cnt == $past(q.cnt) + 16'h0001)
        else $error("main counter did not step");
    // R7 capture stores count
    cap_nb_load_a: assert property ( // R7
        cap_ev[4] & ~q.novw[4] |=> q.cap[4] == $past(q.cnt))
        else $error("non-buffered capture not stored");
    // R8 protected value kept
    novw_keep_a: assert property ( // R8
        cap_ev[5] & q.novw[5] & q.capf[5] & ~crd[5] |=> $stable(q.cap[5]))
        else $error("protected capture overwritten");
    // R6 read empties
    cap_empty_a: assert property ( // R6
        crd[7] & ~cap_ev[7] |=> ~q.capf[7])
        else $error("capture not emptied by read");
    // R9 latch copy
    latch_copy_a: assert property ( // R9
        latch & q.ctrl[ecu_pkg::CT_LQ] & ~q.novw[0] |=> q.holdf[0] && q.hold[0] == $past(q.cap[0]))
        else $error("latch did not copy capture");
    // R11 protected holding kept
    latch_guard_a: assert property ( // R11
        latch & q.ctrl[ecu_pkg::CT_LQ] & q.novw[1] & q.holdf[1] & ~hrd[1]
        |=> $stable(q.hold[1]))
        else $error("protected holding overwritten");
    // R12 queue shift
    queue_shift_a: assert property ( // R12
        cap_ev[1] & ~q.ctrl[ecu_pkg::CT_LQ] & ~q.novw[1] & q.capf[1] & ~crd[1]
        |=> q.hold[1] == $past(q.cap[1]) && q.cap[1] == $past(q.cnt))
        else $error("queue shift wrong");
    // R21 queue accumulator transfer
    pa_queue_a: assert property ( // R21
        hrd[2] & ~q.ctrl[ecu_pkg::CT_LQ] & ~q.ctrl[ecu_pkg::CT_PAIR + 1]
        |=> q.pah[2] == $past(q.pa[2]) && q.pa[2] <= 8'h01)
        else $error("queue accumulator transfer wrong");
    // R20 latch accumulator transfer
    pa_latch_a: assert property ( // R20
        latch & q.ctrl[ecu_pkg::CT_LQ] & ~q.ctrl[ecu_pkg::CT_PAIR + 1]
        |=> q.pah[3] == $past(q.pa[3]) && q.pa[3] <= 8'h01)
        else $error("latch accumulator transfer wrong");
    // R15 saturation holds
    pa_sat_a: assert property ( // R15
        q.ctrl[ecu_pkg::CT_SAT] & ~q.ctrl[ecu_pkg::CT_PAIR] & ~xfer[0]
        & (q.pa[0] == ecu_pkg::SAT_VAL) |=> q.pa[0] == ecu_pkg::SAT_VAL)
        else $error("saturated accumulator wrapped");
    // R22 compare channel never captures
    fsel_gate_a: assert property ( // R22
        q.fsel[6] |=> $stable(q.cap[6]))
        else $error("compare channel captured");
    // R18 zero flag
    mod_zero_a: assert property ( // R18
        zero |=> q.mzf ##1 q.mzf || $past(wr))
        else $error("modulus zero flag lost");

    latch_mode_c: cover property (latch & q.ctrl[ecu_pkg::CT_LQ]);
    queue_shift_c: cover property (cap_ev[0] & ~q.ctrl[ecu_pkg::CT_LQ] & q.capf[0]);
    mod_zero_c: cover property (zero ##[1:40] zero);
    pa_sat_c: cover property (q.ctrl[ecu_pkg::CT_SAT] & (q.pa[0] == ecu_pkg::SAT_VAL) & edg[0]);

endmodule : ecu_capture_top

// file: src/ecu_pkg.sv
// shared constants and state type of the extended capture unit
package ecu_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NCH = 8;
    localparam int NBUF = 4;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_FSEL = 8'h04;
    localparam logic [7:0] ADR_NOVW = 8'h08;
    localparam logic [7:0] ADR_EDGE = 8'h0c;
    localparam logic [7:0] ADR_DLY = 8'h10;
    localparam logic [7:0] ADR_MCTL = 8'h14;
    localparam logic [7:0] ADR_MCNT = 8'h18;
    localparam logic [7:0] ADR_MSTAT = 8'h1c;
    localparam logic [7:0] ADR_TCNT = 8'h20;
    localparam logic [7:0] ADR_FULL = 8'h24;
    // regions: capture 0x40-0x5c, holding 0x60-0x6c, accum 0x70-0x7c, accum hold 0x80-0x8c
    localparam logic [2:0] RGN_CAP = 3'h2;
    localparam logic [3:0] RGN_HOLD = 4'h6;
    localparam logic [3:0] RGN_PA = 4'h7;
    localparam logic [3:0] RGN_PAH = 4'h8;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CT_EN = 0;
    localparam int CT_PS = 1;
    localparam int CT_LQ = 4;
    localparam int CT_SAT = 5;
    localparam int CT_PAIR = 6;
    localparam int MC_EN = 0;
    localparam int MC_PER = 1;
    localparam int MC_PS = 2;
    localparam int MC_ZLAT = 4;
    localparam int MC_FORCE = 5;
    localparam int MS_ZF = 0;

    // ----------------------------------------------------------------
    // values
    // ----------------------------------------------------------------
    localparam logic [7:0] SAT_VAL = 8'hff;
    localparam logic [15:0] MOD_ONE = 16'h0001;
    localparam logic [15:0] ZERO16 = 16'h0000;

    typedef struct packed {
        logic [7:0] s1, s2, flt;
        logic [3:0][7:0] dly;
        logic [7:0] dly_val;
        logic [6:0] pre;
        logic [15:0] cnt;
        logic [3:0] mpre;
        logic [15:0] mcnt, mrld;
        logic mzf;
        logic [4:0] mctl;
        logic [7:0] ctrl, fsel, novw;
        logic [15:0] edge_sel;
        logic [7:0][15:0] cap;
        logic [3:0][15:0] hold;
        logic [7:0] capf;
        logic [3:0] holdf;
        logic [3:0][7:0] pa, pah;
        logic ack;
        logic [31:0] rdat;
    } ecu_st_t;

endpackage : ecu_pkg

// file: verification/ecu_capture_top_tb.sv
// self-checking bench for the extended capture unit
`timescale 1ns/1ps
module ecu_capture_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] t0;
    logic [31:0] t1;
    logic [7:0] pins;
    logic [31:0] dat_o;
    logic ack_o;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    always #2.5 clk_i = ~clk_i;
    ecu_capture_top ecu_capture_top_i (.clk_i(clk_i), .rst_i(rst_i), .ch_pin_i(pins),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o));
    ecu_pin_model ecu_pin_model_i (.clk_i(clk_i), .pin_o(pins));
    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // whole-word access
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // waits for ack_o; with no local timeout, only the bench timeout ends a wait that hangs
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0);
        r = rdat;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask : rc
    task automatic rng(input logic [7:0] a, input logic [15:0] lo, input logic [15:0] hi);
        xfer(1'b0, a, 32'h0);
        chk({31'h0, rdat[15:0] > lo && rdat[15:0] < hi}, 32'h1);
    endtask : rng
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset state
    task automatic t_reset();
        rc(ecu_pkg::ADR_CTRL, 32'h0);
        rc(ecu_pkg::ADR_FULL, 32'h0);
        wr(8'hfc, 32'hffff_ffff);
        rc(8'hfc, 32'h0);
        rc(ecu_pkg::ADR_TCNT, 32'h0);
    endtask : t_reset
    task automatic t_nobuf();
        wr(ecu_pkg::ADR_EDGE, 32'h5555);
        wr(ecu_pkg::ADR_NOVW, 32'h20);
        wr(ecu_pkg::ADR_FSEL, 32'h40);
        wr(ecu_pkg::ADR_CTRL, 32'h1);
        rd(ecu_pkg::ADR_TCNT, t0);
        ecu_pin_model_i.pulse(8'h70, 1);
        rd(ecu_pkg::ADR_TCNT, t1);
        ecu_pin_model_i.pulse(8'h30, 1);
        rc(ecu_pkg::ADR_FULL, 32'h30);
        rng(8'h50, t1[15:0], 16'hffff);
        rng(8'h54, t0[15:0], t1[15:0]);
        rc(ecu_pkg::ADR_FULL, 32'h0);
        wr(ecu_pkg::ADR_FSEL, 32'h0);
    endtask : t_nobuf
    task automatic t_queue();
        ecu_pin_model_i.pulse(8'h01, 1);
        rd(ecu_pkg::ADR_TCNT, t0);
        ecu_pin_model_i.pulse(8'h01, 1);
        rng(8'h60, 16'h0, t0[15:0]);
        rng(8'h40, t0[15:0], 16'hffff);
        rc(8'h80, 32'h2);
        rc(8'h70, 32'h0);
    endtask : t_queue
    task automatic t_latch();
        wr(ecu_pkg::ADR_CTRL, 32'h11);
        ecu_pin_model_i.pulse(8'h02, 3);
        rc(ecu_pkg::ADR_FULL, 32'h2);
        wr(ecu_pkg::ADR_MCTL, 32'h20);
        rc(ecu_pkg::ADR_FULL, 32'hf00);
        rc(8'h84, 32'h3);
        rc(8'h74, 32'h0);
        ecu_pin_model_i.pulse(8'h02, 1);
        wr(ecu_pkg::ADR_MCNT, 32'h0);
        rc(ecu_pkg::ADR_FULL, 32'hf00);
        rc(8'h84, 32'h1);
        wr(ecu_pkg::ADR_NOVW, 32'h2);
        rd(ecu_pkg::ADR_TCNT, t0);
        ecu_pin_model_i.pulse(8'h02, 1);
        wr(ecu_pkg::ADR_MCTL, 32'h20);
        rng(8'h64, 16'h0, t0[15:0]);
        wr(ecu_pkg::ADR_NOVW, 32'h0);
    endtask : t_latch
    task automatic t_sat();
        wr(ecu_pkg::ADR_CTRL, 32'ha1);
        ecu_pin_model_i.pulse(8'h05, 300);
        rc(8'h70, 32'hff);
        rc(8'h78, 32'h2c);
        rc(8'h7c, 32'h1);
    endtask : t_sat
    task automatic t_mod();
        wr(ecu_pkg::ADR_CTRL, 32'h11);
        wr(ecu_pkg::ADR_MCTL, 32'h20);
        ecu_pin_model_i.pulse(8'h01, 2);
        wr(ecu_pkg::ADR_MCTL, 32'h11);
        wr(ecu_pkg::ADR_MCNT, 32'h3);
        // three ticks at divide-by-one reach zero
        repeat (4) @(posedge clk_i);
        rc(ecu_pkg::ADR_MSTAT, 32'h1);
        rc(ecu_pkg::ADR_MCNT, 32'h0);
        rc(8'h80, 32'h2);
        rc(8'h70, 32'h0);
        wr(ecu_pkg::ADR_MSTAT, 32'h1);
        rc(ecu_pkg::ADR_MSTAT, 32'h0);
    endtask : t_mod
    // prescalers, periodic reload and input filter
    task automatic t_misc();
        wr(ecu_pkg::ADR_CTRL, 32'hf);
        rd(ecu_pkg::ADR_TCNT, t0);
        // 515 clocks between the two samples at divide-by-128
        repeat (512) @(posedge clk_i);
        rng(ecu_pkg::ADR_TCNT, t0[15:0] + 16'h0003, t0[15:0] + 16'h0006);
        wr(ecu_pkg::ADR_DLY, 32'h8);
        // four-cycle pulse is shorter than the nine-cycle filter
        ecu_pin_model_i.pulse(8'h08, 1);
        wr(ecu_pkg::ADR_DLY, 32'h2);
        wr(ecu_pkg::ADR_EDGE, 32'h5595);
        ecu_pin_model_i.pulse(8'h08, 1);
        repeat (8) @(posedge clk_i);
        rc(8'h7c, 32'h1);
        wr(ecu_pkg::ADR_MCTL, 32'hd);
        wr(ecu_pkg::ADR_MCNT, 32'h10);
        // divide-by-16 ticks land 16, 32, 48 and 64 clocks after the load
        repeat (64) @(posedge clk_i);
        rc(ecu_pkg::ADR_MCNT, 32'hc);
        wr(ecu_pkg::ADR_MCTL, 32'h7);
        wr(ecu_pkg::ADR_MCNT, 32'h2);
        repeat (40) @(posedge clk_i);
        wr(ecu_pkg::ADR_MSTAT, 32'h1);
        repeat (40) @(posedge clk_i);
        rc(ecu_pkg::ADR_MSTAT, 32'h1);
    endtask : t_misc
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_nobuf();
        t_queue();
        t_latch();
        t_sat();
        t_mod();
        t_misc();
        conclude();
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
endmodule : ecu_capture_top_tb

// file: verification/ecu_pin_model.sv
// pin-side model: drives count and capture edges onto the channel inputs
`timescale 1ns/1ps
module ecu_pin_model (
    output logic [7:0] pin_o,
    input wire logic clk_i
);
    initial begin
        pin_o = 8'h00;
    end
    // ------------------------------------------------------------
    // pulses
    // ------------------------------------------------------------
    // each level held for several clocks, wider than the synchroniser
    task automatic pulse(input logic [7:0] mask, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clk_i);
            pin_o <= pin_o | mask;
            repeat (4) @(posedge clk_i);
            pin_o <= pin_o & ~mask;
            repeat (3) @(posedge clk_i);
        end
    endtask : pulse
endmodule : ecu_pin_model
